// [hw/swr_pkg.sv]
// Constants and types shared by the single-wire identity bus master
package swr_pkg;

  // Clock rate and documented line timing, in microseconds
  localparam int CLK_MHZ                 = 50;
  localparam int RESET_LOW_TIME_US       = 480;
  localparam int RESET_LOW_MAX_US        = 960;
  localparam int RESET_HIGH_TIME_US      = 480;
  localparam int PRESENCE_SAMPLE_TIME_US = 75;
  localparam int WRITE_ZERO_LOW_TIME_US  = 60;
  localparam int WRITE_ONE_LOW_TIME_US   = 1;
  localparam int READ_LOW_TIME_US        = 1;
  localparam int READ_SAMPLE_TIME_US     = 15;
  localparam int SLOT_DURATION_US        = 61;
  localparam int SLOT_RECOVERY_TIME_US   = 1;

  // Cycle counts derived from the times above
  localparam int RESET_LOW_CYC       = RESET_LOW_TIME_US * CLK_MHZ;
  localparam int RESET_LOW_MAX_CYC   = RESET_LOW_MAX_US * CLK_MHZ;
  localparam int RESET_HIGH_CYC      = RESET_HIGH_TIME_US * CLK_MHZ;
  localparam int PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_TIME_US * CLK_MHZ;
  localparam int WRITE_ZERO_LOW_CYC  = WRITE_ZERO_LOW_TIME_US * CLK_MHZ;
  localparam int WRITE_ONE_LOW_CYC   = WRITE_ONE_LOW_TIME_US * CLK_MHZ;
  localparam int READ_LOW_CYC        = READ_LOW_TIME_US * CLK_MHZ;
  localparam int READ_SAMPLE_CYC     = READ_SAMPLE_TIME_US * CLK_MHZ;
  localparam int SLOT_CYC            = SLOT_DURATION_US * CLK_MHZ;
  localparam int SLOT_RECOVERY_CYC   = SLOT_RECOVERY_TIME_US * CLK_MHZ;

  // Check register, bit counting and result buffer depth
  localparam logic [7:0] CRC_POLY     = 8'h8c;
  localparam logic [7:0] CRC_INIT     = 8'h00;
  localparam logic [3:0] BYTE_LAST    = 4'h7;
  localparam logic [3:0] TRIPLET_LAST = 4'h2;
  localparam logic [1:0] BUF_DEPTH    = 2'h2;

  // Operations the user may request
  typedef enum logic [1:0] {
    OP_RESET   = 2'b00,
    OP_WRITE   = 2'b01,
    OP_READ    = 2'b10,
    OP_TRIPLET = 2'b11
  } swr_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RST  = 2'b01,
    ST_SLOT = 2'b10,
    ST_DONE = 2'b11
  } swr_state_t;

  typedef struct packed {
    swr_op_t    op;
    logic [7:0] data;
    logic       dir;
  } swr_cmd_t;

  typedef struct packed {
    swr_op_t    op;
    logic [7:0] data;
    logic       crc_zero;
    logic       flag;
  } swr_res_t;

endpackage

// [hw/swr_master.sv]
// Bus master that drives a single-wire identity device over its line
// What this block does
// - Check register cleared, polynomial X8+X5+X4+1
// - Check bits enter least significant first
// - Shifting whole code in leaves zero
// - Data rate stays below 16.3kbps
// - Idle or suspended line left released high
// - Reset low pulse at most 960us
// - Wait full reset high time before next
// - Reset and presence precede any command
// - Master falling edge starts every slot
// - Commands are eight bits sent out
// - Read-code command only with one slave
// - Search: true bit, complement, then write
// - Both zeros mean conflict; master picks direction
// - Presence sampled inside the sample window
// - Write zero held low, one released early
// - Wait whole slot plus recovery each bit
`timescale 1ns/1ps

module swr_master
  import swr_pkg::*;
#(
  parameter int RST_LOW_CYC  = RESET_LOW_CYC,
  parameter int RST_HIGH_CYC = RESET_HIGH_CYC
) (
  // Clock and reset
  input  wire logic     clock,
  input  wire logic     arst_n,
  // Operation request
  input  wire logic     cmd_valid,
  output logic          cmd_ready,
  input  wire swr_cmd_t cmd,
  // Result stream
  output logic          res_valid,
  input  wire logic     res_ready,
  output swr_res_t      res,
  // Open-drain line
  input  wire logic     line_in,
  output logic          line_out,
  output logic          line_oe_n
);

  // Derived counter marks
  localparam logic [15:0] RST_REL  = 16'(RST_LOW_CYC);
  localparam logic [15:0] RST_SAMP =
    16'(RST_LOW_CYC + PRESENCE_SAMPLE_CYC - 1);
  localparam logic [15:0] RST_END  = 16'(RST_LOW_CYC + RST_HIGH_CYC - 1);
  localparam logic [15:0] RST_HIGH = 16'(RST_HIGH_CYC);
  localparam logic [15:0] RST_MAX  = 16'(RESET_LOW_MAX_CYC);
  localparam logic [15:0] W0_LEN   = 16'(WRITE_ZERO_LOW_CYC);
  localparam logic [15:0] W1_LEN   = 16'(WRITE_ONE_LOW_CYC);
  localparam logic [15:0] RD_LEN   = 16'(READ_LOW_CYC);
  localparam logic [15:0] RD_SAMP  = 16'(READ_SAMPLE_CYC - 1);
  localparam logic [15:0] SLOT_END = 16'(SLOT_CYC + SLOT_RECOVERY_CYC - 1);

  // One step of the check register
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic       b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = {1'b0, c[7:1]} ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  swr_state_t  state;
  swr_op_t     op;
  logic [15:0] cnt;
  logic [3:0]  bit_idx;
  logic [7:0]  sh;
  logic [7:0]  crc;
  logic        user_dir;
  logic        dir;
  logic        tri_t;
  logic        tri_c;
  logic        flag;
  logic        presence_seen;
  swr_res_t    mem [2];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  buf_cnt;

  // Request decode and slot control
  wire         accept     = state == ST_IDLE && cmd_valid;
  wire         refuse     = cmd.op != OP_RESET && !presence_seen;
  wire         slot_write = op == OP_WRITE ||
                            (op == OP_TRIPLET && bit_idx == TRIPLET_LAST);
  wire         slot_val   = (op == OP_WRITE) ? sh[0] : dir;
  wire         slot_zero  = slot_write && !slot_val;
  wire [15:0]  low_len    = slot_zero ? W0_LEN :
                            (slot_write ? W1_LEN : RD_LEN);
  wire         in_slot    = state == ST_SLOT;
  wire         slot_end   = in_slot && cnt == SLOT_END;
  wire         samp       = in_slot && cnt == RD_SAMP && !slot_write;
  wire         pres_samp  = state == ST_RST && cnt == RST_SAMP;
  wire         rst_end    = state == ST_RST && cnt == RST_END;
  wire [3:0]   last_idx   = (op == OP_TRIPLET) ? TRIPLET_LAST : BYTE_LAST;
  wire         last_bit   = bit_idx == last_idx;
  wire         push       = state == ST_DONE && buf_cnt != BUF_DEPTH;
  wire         pop        = res_valid && res_ready;
  wire         pick       = (tri_t ^ line_in) ? tri_t : user_dir;
  wire         drive_low  = (state == ST_RST && cnt < RST_REL) ||
                            (in_slot && cnt < low_len);
  swr_res_t    res_d;

  // Line pins and handshakes
  assign line_out  = 1'b0;
  assign line_oe_n = !drive_low;
  assign cmd_ready = state == ST_IDLE;
  assign res_valid = buf_cnt != 2'h0;
  assign res       = mem[rd_ptr];
  assign res_d.op       = op;
  assign res_d.data     = (op == OP_TRIPLET) ?
                          {5'h00, dir, tri_c, tri_t} : sh;
  assign res_d.crc_zero = crc == CRC_INIT;
  assign res_d.flag     = flag;

  // Sequencer: reset pulse, bit slots, result hand-off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state   <= ST_IDLE;
      cnt     <= 16'h0000;
      bit_idx <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          cnt     <= 16'h0000;
          bit_idx <= 4'h0;
          if (accept) begin
            state <= refuse ? ST_DONE :
                     (cmd.op == OP_RESET) ? ST_RST : ST_SLOT;
          end
        end
        ST_RST: begin
          cnt <= cnt + 16'h0001;
          if (rst_end) begin
            state <= ST_DONE;
          end
        end
        ST_SLOT: begin
          cnt <= slot_end ? 16'h0000 : cnt + 16'h0001;
          if (slot_end) begin
            if (last_bit) begin
              state <= ST_DONE;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        ST_DONE: begin
          if (push) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Operation data, sampled bits and search direction
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      op            <= OP_RESET;
      sh            <= 8'h00;
      user_dir      <= 1'b0;
      dir           <= 1'b0;
      tri_t         <= 1'b0;
      tri_c         <= 1'b0;
      flag          <= 1'b0;
      presence_seen <= 1'b0;
    end else if (accept) begin
      op       <= cmd.op;
      sh       <= cmd.data;
      user_dir <= cmd.dir;
      dir      <= cmd.dir;
      flag     <= refuse;
      if (cmd.op == OP_RESET) begin
        presence_seen <= 1'b0;
      end
    end else if (pres_samp) begin
      presence_seen <= !line_in;
      flag          <= !line_in;
    end else if (samp && op == OP_READ) begin
      sh <= {line_in, sh[7:1]};
    end else if (samp && bit_idx == 4'h0) begin
      tri_t <= line_in;
    end else if (samp) begin
      tri_c <= line_in;
      dir   <= pick;
      flag  <= tri_t & line_in;
    end else if (slot_end && op == OP_WRITE) begin
      sh <= {1'b0, sh[7:1]};
    end
  end

  // Check register over received code bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      crc <= CRC_INIT;
    end else if (accept && cmd.op == OP_RESET) begin
      crc <= CRC_INIT;
    end else if (samp && op == OP_READ) begin
      crc <= crc_step(crc, line_in);
    end else if (slot_end && op == OP_TRIPLET && last_bit) begin
      crc <= crc_step(crc, dir);
    end
  end

  // Two-entry result buffer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= res_d;
        wr_ptr      <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Line timing monitors for the checks below
  logic [15:0] low_run;
  logic [15:0] high_run;
  logic [15:0] fall_gap;
  logic        last_rst;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_run  <= 16'h0000;
      high_run <= 16'hffff;
      fall_gap <= 16'hffff;
      last_rst <= 1'b0;
    end else begin
      low_run  <= !line_oe_n ? low_run + 16'(low_run != 16'hffff) : 16'h0;
      high_run <= line_oe_n ? high_run + 16'(high_run != 16'hffff) : 16'h0;
      fall_gap <= (!line_oe_n && high_run != 16'h0000) ? 16'h0001 :
                  fall_gap + 16'(fall_gap != 16'hffff);
      last_rst <= (state == ST_RST) ? 1'b1 : (in_slot ? 1'b0 : last_rst);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_reset_len;
    (state == ST_RST && cnt == RST_REL) |-> low_run == RST_REL;
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("reset pulse length wrong");

  property p_reset_max;
    low_run <= RST_MAX;
  endproperty
  a_reset_max: assert property (p_reset_max)
    else $error("line held low too long");

  property p_write_zero;
    (in_slot && cnt == W0_LEN && slot_zero) |-> low_run == W0_LEN;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("write zero low time wrong");

  property p_short_low;
    (in_slot && cnt == W1_LEN && !slot_zero) |->
      line_oe_n && $past(low_run) == W1_LEN - 16'h1;
  endproperty
  a_short_low: assert property (p_short_low)
    else $error("short slot low time wrong");

  property p_slot_gap;
    ($fell(line_oe_n) && in_slot) |-> fall_gap >= SLOT_END + 16'h1;
  endproperty
  a_slot_gap: assert property (p_slot_gap)
    else $error("slots too close together");

  property p_reset_high;
    ($fell(line_oe_n) && last_rst) |-> high_run >= RST_HIGH;
  endproperty
  a_reset_high: assert property (p_reset_high)
    else $error("reset high time cut short");

  property p_idle_released;
    state == ST_IDLE |-> line_oe_n;
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("line driven while idle");

  property p_refuse;
    (accept && refuse) |=> state == ST_DONE && flag;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("command ran without presence");

  property p_crc_clear;
    (accept && cmd.op == OP_RESET) |=> crc == CRC_INIT;
  endproperty
  a_crc_clear: assert property (p_crc_clear)
    else $error("check register not cleared");

  property p_dir;
    (in_slot && op == OP_TRIPLET && bit_idx == TRIPLET_LAST) |->
      dir == ((tri_t ^ tri_c) ? tri_t : user_dir);
  endproperty
  a_dir: assert property (p_dir)
    else $error("search direction wrong");

  property p_presence;
    pres_samp |=> presence_seen == !$past(line_in);
  endproperty
  a_presence: assert property (p_presence)
    else $error("presence not captured");

  property p_cov_presence;
    pres_samp && !line_in;
  endproperty
  c_cov_presence: cover property (p_cov_presence);
  property p_cov_conflict;
    samp && op == OP_TRIPLET && bit_idx == 4'h1 && !tri_t && !line_in;
  endproperty
  c_cov_conflict: cover property (p_cov_conflict);
  property p_cov_full;
    buf_cnt == BUF_DEPTH && state == ST_DONE;
  endproperty
  c_cov_full: cover property (p_cov_full);
endmodule

// [test/swr_dev_model.sv]
// Behavioural model of the identity device on the shared line
`timescale 1ns/1ps

module swr_dev_model #(
  parameter logic [7:0]  FAMILY  = 8'h5a,           // Arbitrary value
  parameter logic [47:0] SERIAL  = 48'h0123456789ab, // Arbitrary value
  parameter bit          VARIANT = 1'b0   // Answers select and broadcast
) (
  // Shared line
  input  wire logic line,
  output logic      pull
);
  localparam int RST_NS    = 120000;
  localparam int PDH_NS    = 20000;
  localparam int PDL_NS    = 100000;
  localparam int SAMPLE_NS = 30000;
  localparam int HOLD_NS   = 30000;

  logic [63:0] code;
  logic [7:0]  cmd_sr;
  logic        b;
  int          mode;
  int          idx;
  int          phase;
  time         t_fall;

  // Check byte over the first 56 bits, register cleared first
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 8'h8c : c >> 1;
    end
    return c;
  endfunction

  // Family in the low byte, then serial, then check byte
  assign code = {crc8({SERIAL, FAMILY}), SERIAL, FAMILY};

  initial begin
    pull = 1'b0;
    mode = 0;
    t_fall = 0;
  end

  // A long low is a reset: abandon all, then answer with presence
  always @(posedge line) begin
    if ($time - t_fall > RST_NS) begin
      mode = 0;
      idx = 0;
      phase = 0;
      #PDH_NS;
      pull = 1'b1;
      #PDL_NS;
      t_fall = $time;
      pull = 1'b0;
      mode = 1;
    end
  end

  // Each master falling edge opens a slot timed from that edge
  always @(negedge line) begin
    if (!pull) begin
      t_fall = $time;
      if (mode == 1) begin
        #SAMPLE_NS;
        cmd_sr = {line, cmd_sr[7:1]};
        idx++;
        if (idx == 8) begin
          idx = 0;
          phase = 0;
          mode = (cmd_sr == 8'h33) ? 2 : (cmd_sr == 8'hf0) ? 3 : 0;
          if (VARIANT && (cmd_sr == 8'h55 || cmd_sr == 8'hcc)) begin
            mode = 2;
          end
        end
      end else if (mode == 3 && phase == 2) begin
        #SAMPLE_NS;
        phase = 0;
        idx++;
        if (line !== code[idx-1] || idx == 64) mode = 0;
      end else if (mode >= 2) begin
        b = (mode == 3 && phase == 1) ? ~code[idx] : code[idx];
        if (mode == 3) phase++;
        else idx++;
        if (mode == 2 && idx == 64) mode = 0;
        if (!b) begin
          pull = 1'b1;
          #HOLD_NS;
          pull = 1'b0;
        end
      end
    end
  end
endmodule

// [test/swr_master_tb.sv]
// Testbench for the single-wire identity bus master
`timescale 1ns/1ps

module swr_master_tb;
  import swr_pkg::*;

  localparam int         RST_LOW  = 6500;
  localparam int         RST_HIGH = 6500;
  localparam int         LIMIT    = 130000;
  localparam logic [7:0] FAM      = 8'h5a; // Arbitrary family value
  localparam logic [7:0] FAM2     = 8'h59; // Arbitrary, differs in bits 1:0

  logic     clock;
  logic     arst_n;
  logic     cmd_valid;
  logic     cmd_ready;
  swr_cmd_t cmd;
  logic     res_valid;
  logic     res_ready;
  swr_res_t res;
  logic     line;
  logic     line_out;
  logic     line_oe_n;
  logic     pull;
  logic     pull2;
  logic     two_dev;
  int       fails;
  int       check_count;
  int       cycles;
  swr_res_t r;

  swr_master #(.RST_LOW_CYC(RST_LOW), .RST_HIGH_CYC(RST_HIGH)) dut (
    .clock(clock), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .res_valid(res_valid),
    .res_ready(res_ready), .res(res), .line_in(line),
    .line_out(line_out), .line_oe_n(line_oe_n));

  swr_dev_model #(.FAMILY(FAM)) model (.line(line), .pull(pull));

  // Second device, attached to the wire only while two_dev is set
  swr_dev_model #(.FAMILY(FAM2)) model2 (.line(line), .pull(pull2));

  // Pulled-up wire: low if any attached party pulls
  assign line = (line_oe_n ? 1'b1 : line_out) & ~pull & ~(pull2 & two_dev);

  always #10 clock = ~clock;

  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end

  function automatic logic [11:0] mk(swr_op_t op, logic [7:0] d,
                                     logic c, logic f);
    return {op, d, c, f};
  endfunction

  task automatic check(input logic [11:0] got, input logic [11:0] exp,
                       input logic [11:0] mask, input string what);
    check_count++;
    if ((got & mask) !== (exp & mask)) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic issue(input swr_op_t op, input logic [7:0] d,
                       input logic dir);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd = '{op, d, dir};
    while (cmd_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask

  task automatic take(output swr_res_t got);
    @(negedge clock);
    res_ready = 1'b1;
    while (res_valid !== 1'b1) @(negedge clock);
    got = res;
    @(negedge clock);
    res_ready = 1'b0;
  endtask

  // Reset with presence, then one command byte on the line
  task automatic open_cmd(input logic [7:0] c);
    issue(OP_RESET, 8'h00, 1'b0);
    take(r);
    check(r, mk(OP_RESET, 8'h00, 1'b1, 1'b1), 12'hc03, "presence");
    issue(OP_WRITE, c, 1'b0);
    take(r);
    check(r, mk(OP_WRITE, 8'h00, 1'b0, 1'b0), 12'hffd, "write");
  endtask

  // Refused ops fill the buffer while the consumer stalls
  task automatic t_buffer();
    issue(OP_READ, 8'h00, 1'b0);
    issue(OP_WRITE, 8'h33, 1'b0);
    issue(OP_TRIPLET, 8'h00, 1'b0);
    repeat (10) @(negedge clock);
    check({cmd_ready, res_valid, line_oe_n}, 12'h003, 12'h007, "full");
    take(r);
    check(r, mk(OP_READ, 8'h00, 1'b0, 1'b1), 12'hc01, "ref rd");
    take(r);
    check(r, mk(OP_WRITE, 8'h00, 1'b0, 1'b1), 12'hc01, "ref wr");
    take(r);
    check(r, mk(OP_TRIPLET, 8'h00, 1'b0, 1'b1), 12'hc01, "ref tr");
    $display("test buffer done");
  endtask

  // Read-code command returns the family byte first
  task automatic t_read();
    open_cmd(8'h33);
    issue(OP_READ, 8'h00, 1'b0);
    take(r);
    check(r, mk(OP_READ, FAM, 1'b0, 1'b0), 12'hfff, "family");
    $display("test read done");
  endtask

  // Search with two devices: the conflict picks the second, the first drops
  task automatic t_search();
    two_dev = 1'b1;
    open_cmd(8'hf0);
    issue(OP_TRIPLET, 8'h00, FAM2[0]);
    take(r);
    check(r, mk(OP_TRIPLET, {5'h00, FAM2[0], 2'b00}, 1'b0, 1'b0), 12'hffd, "conflict");
    issue(OP_TRIPLET, 8'h00, FAM[1]);
    take(r);
    check(r, mk(OP_TRIPLET, {5'h00, FAM2[1], ~FAM2[1], FAM2[1]}, 1'b0, 1'b0), 12'hffd, "dropped");
    $display("test search done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    res_ready = 1'b0;
    two_dev = 1'b0;
    fails = 0;
    check_count = 0;
    cycles = 0;
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    check({cmd_ready, res_valid, line_oe_n}, 12'h005, 12'h007, "idle");
    t_buffer();
    t_read();
    t_search();
    conclude();
  end
endmodule
